//--- hdl/spil_top.sv
// interrupt and clock-source side of one serial channel
// assumes the data path pulses the flag-set inputs and the
// interrupt controller pulses the accept inputs
//
// Local design decisions: the plain strobed port and the address map.
`include "spil_map.svh"
module spil_top
    import spil_pkg::*;
#(
    parameter bit TIMER_CLK_AVAIL = 1'b1
) (
    input  wire logic        i_ref_clk,
    input  wire logic        i_reset_n,
    input  wire logic [7:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic [31:0]      o_rdata,
    input  wire logic        i_tx_empty_set,
    input  wire logic        i_tx_end_set,
    input  wire logic        i_rx_full_set,
    input  wire logic        i_overrun_set,
    input  wire logic        i_framing_set,
    input  wire logic        i_parity_set,
    input  wire logic        i_timer_tick,
    input  wire logic        i_rx_accept,
    input  wire logic        i_tx_accept,
    output logic             o_bit_tick,
    output logic             o_rx_full_request,
    output logic             o_tx_empty_request,
    output logic             o_group_req,
    output logic             o_rx_dtc_req,
    output logic             o_rx_dma_req,
    output logic             o_tx_dtc_req,
    output logic             o_tx_dma_req,
    output logic [2:0]       o_prio_src,
    output logic             o_irq,
    output logic             o_mod_stop
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [`SPIL_CTRL_W-1:0] ctrl_q;
    logic [`SPIL_STAT_W-1:0] stat_q;
    logic [`SPIL_STAT_W-1:0] rd_one_q;
    logic [`SPIL_STAT_W-1:0] stat_set;
    logic [7:0]              brr_q;
    logic [1:0]              gen_q;
    logic [1:0]              gs_q;
    logic [2:0]              istat_q;
    logic [2:0]              imask_q;
    logic [2:0]              ev;
    logic                    rx_lvl;
    logic                    tx_lvl;
    logic                    tx_end_flag_lvl;
    logic                    err_lvl;
    logic                    rx_lvl_q;
    logic                    tx_lvl_q;
    logic                    tx_end_flag_lvl_q;
    logic                    err_lvl_q;
    logic                    rx_set;
    logic                    tx_set;
    logic                    wr_ctrl;
    logic                    wr_stat;
    logic                    stop;
    spil_route_e             rx_route;
    spil_route_e             tx_route;
    spil_src_e               src_d;

    // read-one-then-write-zero clear, a fresh set always wins
    function automatic logic [`SPIL_STAT_W-1:0] flag_next(
        input logic [`SPIL_STAT_W-1:0] q,
        input logic [`SPIL_STAT_W-1:0] set,
        input logic [`SPIL_STAT_W-1:0] rd1,
        input logic                    we,
        input logic [`SPIL_STAT_W-1:0] wd
    );
        flag_next = set | (q & ~({`SPIL_STAT_W{we}} & ~wd & rd1));
    endfunction

    // write-one-to-clear for the interrupt log, set wins
    function automatic logic [2:0] w1c_next(
        input logic [2:0] q,
        input logic [2:0] set,
        input logic       we,
        input logic [2:0] wd
    );
        w1c_next = set | (q & ~({3{we}} & wd));
    endfunction

    assign stop     = ctrl_q[`SPIL_C_MSTP];
    assign wr_ctrl  = i_wr && (i_addr == `SPIL_OFS_CTRL);
    assign wr_stat  = i_wr && (i_addr == `SPIL_OFS_STAT);
    assign rx_route = spil_route_e'(ctrl_q[`SPIL_C_RXRT]);
    assign tx_route = spil_route_e'(ctrl_q[`SPIL_C_TXRT]);

    // ------------------------------------------------------------
    // request levels from flags and enables
    // ------------------------------------------------------------
    // errors share the receive enable with receive full
    assign err_lvl  = ctrl_q[`SPIL_C_RIE] & (stat_q[`SPIL_S_OVERRUN_FLAG] | stat_q[`SPIL_S_FER]
                      | stat_q[`SPIL_S_PER]);
    assign rx_lvl   = ctrl_q[`SPIL_C_RIE] & stat_q[`SPIL_S_RFULL];
    assign tx_lvl   = ctrl_q[`SPIL_C_TIE] & stat_q[`SPIL_S_TEMPTY];
    assign tx_end_flag_lvl = ctrl_q[`SPIL_C_TX_END_IRQ_EN] & stat_q[`SPIL_S_TX_END_FLAG];

    // channel logic ignores events while its clock is withheld
    assign stat_set = stop ? '0 : {i_parity_set, i_framing_set, i_overrun_set,
                                   i_rx_full_set, i_tx_end_set, i_tx_empty_set};

    // ------------------------------------------------------------
    // control, divider and enable registers
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctrl_q  <= `SPIL_CTRL_RST;
            brr_q   <= `SPIL_BRR_RST;
            gen_q   <= 2'b00;
            imask_q <= 3'b000;
        end else if (i_wr) begin
            if (wr_ctrl) begin
                ctrl_q <= i_wdata[`SPIL_CTRL_W-1:0];
            end
            if (i_addr == `SPIL_OFS_BRR) begin
                brr_q <= i_wdata[7:0];
            end
            if (i_addr == `SPIL_OFS_GEN) begin
                gen_q <= i_wdata[1:0];
            end
            if (i_addr == `SPIL_OFS_IMASK) begin
                imask_q <= i_wdata[2:0];
            end
        end
    end

    // ------------------------------------------------------------
    // channel status flags
    // ------------------------------------------------------------
    // only bits seen as one by a status read may be cleared;
    // frozen entirely in module stop
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            stat_q   <= `SPIL_STAT_RST;
            rd_one_q <= '0;
        end else if (!stop) begin
            stat_q <= flag_next(stat_q, stat_set, rd_one_q, wr_stat,
                                i_wdata[`SPIL_STAT_W-1:0]);
            if (i_rd && (i_addr == `SPIL_OFS_STAT)) begin
                rd_one_q <= stat_q;
            end else if (wr_stat) begin
                rd_one_q <= '0;
            end
        end
    end

    // ------------------------------------------------------------
    // edge detectors on request levels
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rx_lvl_q   <= 1'b0;
            tx_lvl_q   <= 1'b0;
            tx_end_flag_lvl_q <= 1'b0;
            err_lvl_q  <= 1'b0;
        end else begin
            rx_lvl_q   <= rx_lvl;
            tx_lvl_q   <= tx_lvl;
            tx_end_flag_lvl_q <= tx_end_flag_lvl;
            err_lvl_q  <= err_lvl;
        end
    end

    // ------------------------------------------------------------
    // dedicated vectors with held requests
    // ------------------------------------------------------------
    spil_req_latch u_rx_vec (
        .i_ref_clk (i_ref_clk),
        .i_reset_n (i_reset_n),
        .i_req     (rx_lvl & ~rx_lvl_q),
        .i_accept  (i_rx_accept),
        .o_pend    (o_rx_full_request),
        .o_set     (rx_set)
    );

    spil_req_latch u_tx_vec (
        .i_ref_clk (i_ref_clk),
        .i_reset_n (i_reset_n),
        .i_req     (tx_lvl & ~tx_lvl_q),
        .i_accept  (i_tx_accept),
        .o_pend    (o_tx_empty_request),
        .o_set     (tx_set)
    );

    // ------------------------------------------------------------
    // group member status and shared request
    // ------------------------------------------------------------
    // member bit follows its source down, so no separate clear is needed
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            gs_q        <= 2'b00;
            o_group_req <= 1'b0;
        end else begin
            gs_q[`SPIL_G_TX_END_FLAG] <= (tx_end_flag_lvl & ~tx_end_flag_lvl_q)
                                  | (gs_q[`SPIL_G_TX_END_FLAG] & stat_q[`SPIL_S_TX_END_FLAG]);
            gs_q[`SPIL_G_ERR]  <= (err_lvl & ~err_lvl_q)
                                  | (gs_q[`SPIL_G_ERR] & (stat_q[`SPIL_S_OVERRUN_FLAG]
                                  | stat_q[`SPIL_S_FER] | stat_q[`SPIL_S_PER]));
            o_group_req        <= |(gs_q & gen_q);
        end
    end

    // ------------------------------------------------------------
    // transfer controller triggers
    // ------------------------------------------------------------
    // only full and empty may start transfers; error and end never do
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rx_dtc_req <= 1'b0;
            o_rx_dma_req <= 1'b0;
            o_tx_dtc_req <= 1'b0;
            o_tx_dma_req <= 1'b0;
        end else begin
            o_rx_dtc_req <= rx_set && (rx_route == ROUTE_DTC);
            o_rx_dma_req <= rx_set && (rx_route == ROUTE_DMA);
            o_tx_dtc_req <= tx_set && (tx_route == ROUTE_DTC);
            o_tx_dma_req <= tx_set && (tx_route == ROUTE_DMA);
        end
    end

    // ------------------------------------------------------------
    // priority of active sources
    // ------------------------------------------------------------
    always_comb begin
        if (gs_q[`SPIL_G_ERR] && gen_q[`SPIL_G_ERR]) begin
            src_d = SRC_RX_ERR;
        end else if (o_rx_full_request) begin
            src_d = SRC_RX_FULL;
        end else if (o_tx_empty_request) begin
            src_d = SRC_TX_EMPTY;
        end else if (gs_q[`SPIL_G_TX_END_FLAG] && gen_q[`SPIL_G_TX_END_FLAG]) begin
            src_d = SRC_TX_END;
        end else begin
            src_d = SRC_NONE;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_prio_src <= 3'h0;
        end else begin
            o_prio_src <= src_d;
        end
    end

    // ------------------------------------------------------------
    // interrupt log, mask and cpu interrupt
    // ------------------------------------------------------------
    assign ev = {o_group_req, tx_set, rx_set};

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            istat_q <= 3'b000;
            o_irq   <= 1'b0;
        end else begin
            istat_q <= w1c_next(istat_q, ev, i_wr && (i_addr == `SPIL_OFS_ISTAT), i_wdata[2:0]);
            o_irq   <= |(istat_q & imask_q);
        end
    end

    // ------------------------------------------------------------
    // register read port; unmapped reads return zero
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rdata <= 32'h0000_0000;
        end else begin
            o_rdata <= 32'h0000_0000;
            if (i_rd) begin
                case (i_addr)
                    `SPIL_OFS_CTRL:  o_rdata[`SPIL_CTRL_W-1:0] <= ctrl_q;
                    `SPIL_OFS_STAT:  o_rdata[`SPIL_STAT_W-1:0] <= stat_q;
                    `SPIL_OFS_BRR:   o_rdata[7:0] <= brr_q;
                    `SPIL_OFS_GEN:   o_rdata[1:0] <= gen_q;
                    `SPIL_OFS_GSTAT: o_rdata[1:0] <= gs_q;
                    `SPIL_OFS_ISTAT: o_rdata[2:0] <= istat_q;
                    `SPIL_OFS_IMASK: o_rdata[2:0] <= imask_q;
                    default:         o_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_mod_stop <= 1'b1;
        end else begin
            o_mod_stop <= stop;
        end
    end

    // ------------------------------------------------------------
    // baud base clock; withheld in module stop
    // ------------------------------------------------------------
    spil_baud_gen u_baud (
        .i_ref_clk    (i_ref_clk),
        .i_reset_n    (i_reset_n),
        .i_stop       (stop),
        .i_timer_sel  (TIMER_CLK_AVAIL && ctrl_q[`SPIL_C_TMRSEL]),
        .i_timer_tick (i_timer_tick),
        .i_eight      (ctrl_q[`SPIL_C_ABCS]),
        .i_div        (brr_q),
        .o_bit_tick   (o_bit_tick)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);

    sequence rx_rise_s;
        rx_lvl && !rx_lvl_q && !o_rx_full_request;
    endsequence

    sequence err_pending_s;
        gs_q[`SPIL_G_ERR] && gen_q[`SPIL_G_ERR];
    endsequence

    stop_freezes_flags_a: assert property (stop |=> $stable(stat_q))
        else $error("status changed in module stop");
    rx_full_raise_a: assert property (rx_rise_s |=> o_rx_full_request)
        else $error("receive full request not raised");
    group_req_a: assert property (|(gs_q & gen_q) |=> o_group_req)
        else $error("group request missing");
    group_autoclr_a: assert property (!stat_q[`SPIL_S_TX_END_FLAG] && !tx_end_flag_lvl |=> !gs_q[`SPIL_G_TX_END_FLAG])
        else $error("group status not cleared with flag");
    err_priority_a: assert property (err_pending_s |=> o_prio_src == 3'(SRC_RX_ERR))
        else $error("receive error not highest priority");
    rx_dma_route_a: assert property (rx_set && rx_route == ROUTE_DMA |=> o_rx_dma_req ##1 !o_rx_dma_req)
        else $error("dma trigger wrong");
    tx_empty_gate_a: assert property (!ctrl_q[`SPIL_C_TIE] && !o_tx_empty_request && !u_tx_vec.held_q
                                      |=> !o_tx_empty_request)
        else $error("transmit empty request without enable");
endmodule

//--- shared/spil_map.svh
// register map, field positions and reset values of the serial port interrupt logic
// assumes a 32-bit plain register port with word-aligned byte addresses
//
// Behaviour
// - in asynchronous mode software picks 8 or 16 base clock cycles per bit period.
// - where offered, an on-chip timer output may replace the internal base clock.
// - receive-full and transmit-empty requests may start the transfer controller or the dma controller.
// - priority is receive error, receive full, transmit empty, transmit end; error and end never start transfers.
// - a receive-full or transmit-empty request seen while its pending flag is set is held and replayed later.
// - a vector pending flag clears itself when the processor accepts that interrupt.
// - a group member status bit clears once the matching channel status flag is cleared.
// - transmit end and receive error share a group with per-member enable and status; the others own a vector.
// - after reset the channel sits in module stop with its clock withheld until software cancels it.
// - receive error comes from overrun, framing or parity flags and shares the receive enable with receive full.
// - transmit empty follows its flag and enable; transmit end follows its flag and its own enable.
`ifndef SPIL_MAP_SVH
`define SPIL_MAP_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define SPIL_OFS_CTRL   8'h00
`define SPIL_OFS_STAT   8'h04
`define SPIL_OFS_BRR    8'h08
`define SPIL_OFS_GEN    8'h0C
`define SPIL_OFS_GSTAT  8'h10
`define SPIL_OFS_ISTAT  8'h14
`define SPIL_OFS_IMASK  8'h18

// ------------------------------------------------------------
// control fields
// ------------------------------------------------------------
`define SPIL_CTRL_W     10
`define SPIL_CTRL_RST   10'h001
`define SPIL_C_MSTP     0
`define SPIL_C_RIE      1
`define SPIL_C_TIE      2
`define SPIL_C_TX_END_IRQ_EN     3
`define SPIL_C_ABCS     4
`define SPIL_C_TMRSEL   5
`define SPIL_C_RXRT     7:6
`define SPIL_C_TXRT     9:8

// ------------------------------------------------------------
// status, group and interrupt fields
// ------------------------------------------------------------
`define SPIL_STAT_W     6
`define SPIL_STAT_RST   6'h03
`define SPIL_S_TEMPTY   0
`define SPIL_S_TX_END_FLAG     1
`define SPIL_S_RFULL    2
`define SPIL_S_OVERRUN_FLAG     3
`define SPIL_S_FER      4
`define SPIL_S_PER      5
`define SPIL_G_TX_END_FLAG     0
`define SPIL_G_ERR      1
`define SPIL_I_RX       0
`define SPIL_I_TX       1
`define SPIL_I_GRP      2
`define SPIL_BRR_RST    8'hFF
`define SPIL_BIT8       4'h7
`define SPIL_BIT16      4'hF

`endif

//--- shared/spil_pkg.sv
// types shared by the serial port interrupt logic
// assumes nothing beyond the register map header
package spil_pkg;
    // where a data request is sent besides the cpu interrupt
    typedef enum logic [1:0] {ROUTE_CPU, ROUTE_DTC, ROUTE_DMA} spil_route_e;
    // highest-priority active request source
    typedef enum logic [2:0] {SRC_NONE, SRC_RX_ERR, SRC_RX_FULL, SRC_TX_EMPTY, SRC_TX_END} spil_src_e;
endpackage

//--- hdl/spil_req_latch.sv
// pending flag of one dedicated vector with a one-deep held request
// assumes i_req is a one-cycle event and i_accept comes from the interrupt controller
module spil_req_latch (
    input  wire logic i_ref_clk,
    input  wire logic i_reset_n,
    input  wire logic i_req,
    input  wire logic i_accept,
    output logic      o_pend,
    output logic      o_set
);
    logic held_q;
    logic set_now;

    // a held or fresh request sets the flag only once it is free
    assign set_now = (i_req | held_q) & ~o_pend;

    // ------------------------------------------------------------
    // pending flag and held request
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_pend <= 1'b0;
            held_q <= 1'b0;
            o_set  <= 1'b0;
        end else begin
            o_pend <= set_now | (o_pend & ~i_accept);
            held_q <= (i_req | held_q) & o_pend;
            o_set  <= set_now;
        end
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);

    held_replay_a: assert property (held_q && !o_pend |=> o_pend && !held_q)
        else $error("held request not replayed");
    accept_clears_a: assert property (o_pend && i_accept |=> !o_pend)
        else $error("pending flag survived accept");
endmodule

//--- hdl/spil_baud_gen.sv
// bit period tick from internal divider or on-chip timer clock
// assumes i_timer_tick is a one-cycle pulse synchronous to i_ref_clk
`include "spil_map.svh"
module spil_baud_gen (
    input  wire logic       i_ref_clk,
    input  wire logic       i_reset_n,
    input  wire logic       i_stop,
    input  wire logic       i_timer_sel,
    input  wire logic       i_timer_tick,
    input  wire logic       i_eight,
    input  wire logic [7:0] i_div,
    output logic            o_bit_tick
);
    logic [7:0] div_q;
    logic [3:0] phase_q;
    logic       base_tick;
    logic [3:0] phase_end;

    // timer clock replaces the divider when selected
    assign base_tick = i_timer_sel ? i_timer_tick : (div_q == 8'h00);
    assign phase_end = i_eight ? `SPIL_BIT8 : `SPIL_BIT16;

    // ------------------------------------------------------------
    // divider and bit phase; cleared to zero in module stop
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            div_q      <= 8'h00;
            phase_q    <= 4'h0;
            o_bit_tick <= 1'b0;
        end else if (i_stop) begin
            div_q      <= 8'h00;
            phase_q    <= 4'h0;
            o_bit_tick <= 1'b0;
        end else begin
            div_q      <= (div_q == 8'h00) ? i_div : div_q - 8'h01;
            o_bit_tick <= base_tick && (phase_q >= phase_end);
            if (base_tick) begin
                phase_q <= (phase_q >= phase_end) ? 4'h0 : phase_q + 4'h1;
            end
        end
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);

    stop_no_tick_a: assert property (i_stop |=> !o_bit_tick)
        else $error("bit tick while stopped");
    // phase may sit above the eight-cycle end after a mode switch until the next base tick
    eight_phase_a: assert property (i_eight && !i_stop && base_tick |=> phase_q <= `SPIL_BIT8)
        else $error("phase beyond eight cycles");
endmodule

//--- tb/spil_icu_model.sv
// interrupt controller stand-in that takes pending rx and tx vectors
// assumes the vector requests are levels held until accepted
module spil_icu_model #(
    parameter int DLY = 4
) (
    input  wire logic i_ref_clk,
    input  wire logic i_reset_n,
    input  wire logic i_en,
    input  wire logic i_rx_req,
    input  wire logic i_tx_req,
    output logic      o_rx_acc,
    output logic      o_tx_acc
);
    timeunit 1ns;
    timeprecision 1ps;
    int rx_cnt_q;
    int tx_cnt_q;
    // accept after DLY cycles; i_en low models a busy processor
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rx_cnt_q <= 0;
            tx_cnt_q <= 0;
            o_rx_acc <= 1'b0;
            o_tx_acc <= 1'b0;
        end else begin
            rx_cnt_q <= (i_rx_req && !o_rx_acc) ? rx_cnt_q + 1 : 0;
            tx_cnt_q <= (i_tx_req && !o_tx_acc) ? tx_cnt_q + 1 : 0;
            o_rx_acc <= i_en && i_rx_req && !o_rx_acc && rx_cnt_q >= DLY;
            o_tx_acc <= i_en && i_tx_req && !o_tx_acc && tx_cnt_q >= DLY;
        end
    end
endmodule

//--- tb/testbench.sv
// self-checking bench for the serial port interrupt logic
// assumes the design and the interrupt controller stand-in
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_ref_clk, i_reset_n, i_wr, i_rd, i_timer_tick, i_rx_accept, i_tx_accept;
    logic        acc_en, tmr_on, o_bit_tick, o_rx_full_request, o_tx_empty_request, o_group_req;
    logic        o_rx_dtc_req, o_rx_dma_req, o_tx_dtc_req, o_tx_dma_req, o_irq, o_mod_stop;
    logic [2:0]  o_prio_src;
    logic [5:0]  fs;
    logic [7:0]  i_addr;
    logic [31:0] i_wdata, o_rdata, rv;
    int          error_cnt, n_compared, n;
    logic [7:0]  ra [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h1C};
    logic [31:0] rx [5] = '{32'h1, 32'h3, 32'hFF, 32'h0, 32'h0};
    logic [9:0]  cc [3] = '{10'h19E, 10'h18E, 10'h1BE};
    int          pp [3] = '{8, 16, 16};

    spil_top #(.TIMER_CLK_AVAIL(1'b1)) i_dut (.i_tx_empty_set(fs[0]), .i_tx_end_set(fs[1]),
        .i_rx_full_set(fs[2]), .i_overrun_set(fs[3]), .i_framing_set(fs[4]), .i_parity_set(fs[5]), .*);
    spil_icu_model #(.DLY(4)) i_icu (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_en(acc_en),
        .i_rx_req(o_rx_full_request), .i_tx_req(o_tx_empty_request), .o_rx_acc(i_rx_accept),
        .o_tx_acc(i_tx_accept));

    // ------------------------------------------------------------
    // clock, timer ticks every second cycle, watchdog
    // ------------------------------------------------------------
    initial begin
        i_ref_clk = 1'b0;
        forever #12.5 i_ref_clk = ~i_ref_clk;
    end
    always @(posedge i_ref_clk) i_timer_tick <= tmr_on & ~i_timer_tick;
    initial begin
        #200us;
        error_cnt++;
        print_verdict();
    end

    task automatic cyc(input int k);
        repeat (k) @(posedge i_ref_clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1;
        rv = o_rdata;
    endtask
    task automatic pl(input logic [5:0] m);
        @(posedge i_ref_clk);
        fs <= m;
        @(posedge i_ref_clk);
        fs <= 6'h00;
    endtask
    task automatic print_verdict();
        if (error_cnt == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {i_reset_n, i_wr, i_rd, acc_en, tmr_on} = 5'h00;
        {i_addr, i_wdata, fs} = 46'h0;
        error_cnt = 0;
        n_compared = 0;
        repeat (12) @(posedge i_ref_clk);
        i_reset_n <= 1'b1;
        pl(6'h04); // flag pulse must be ignored while stopped
        for (int i = 0; i < 5; i++) begin
            rd(ra[i]);
            chk("reset reg", rx[i], rv);
        end
        // divider set to zero while stopped, so no stale count delays the base tick
        wr(8'h08, 32'h0);
        acc_en <= 1'b1;
        wr(8'h18, 32'h1);
        wr(8'h00, 32'h18E);
        cyc(1);
        chk("mod_stop", 0, o_mod_stop);
        chk("tx request", 1, o_tx_empty_request);
        cyc(1);
        chk("tx dtc", 1, o_tx_dtc_req);
        chk("tx dma", 0, o_tx_dma_req);
        chk("tx prio", 3, o_prio_src);
        pl(6'h04);
        cyc(1);
        chk("rx request", 1, o_rx_full_request);
        cyc(1);
        chk("rx dma", 1, o_rx_dma_req);
        chk("rx dtc", 0, o_rx_dtc_req);
        chk("rx prio", 2, o_prio_src);
        cyc(1);
        chk("irq", 1, o_irq);
        wr(8'h18, 32'h0);
        cyc(1);
        chk("irq masked", 0, o_irq);
        wr(8'h14, 32'h1);
        wr(8'h18, 32'h1);
        cyc(1);
        chk("irq cleared", 0, o_irq);
        wr(8'h04, 32'h0); // zero without a prior read is refused
        rd(8'h04);
        chk("rx flag kept", 1, rv[2]);
        wr(8'h04, 32'h0);
        rd(8'h04);
        chk("stat cleared", 0, rv);
        // held request replays once the busy processor accepts
        acc_en <= 1'b0;
        pl(6'h04);
        cyc(2);
        rd(8'h04);
        wr(8'h04, 32'h0);
        pl(6'h04);
        acc_en <= 1'b1;
        for (n = 0; n < 20 && o_rx_full_request === 1'b1; n++) cyc(1);
        chk("accept drop", 1, n < 20);
        cyc(2);
        chk("replayed", 1, o_rx_full_request);
        rd(8'h04);
        wr(8'h04, 32'h0);
        wr(8'h0C, 32'h3);
        for (int i = 0; i < 3; i++) begin
            pl(6'h08 << i);
            cyc(3);
            chk("err group", 1, o_group_req);
            chk("err prio", 1, o_prio_src);
            rd(8'h10);
            chk("gstat err", 2, rv);
            rd(8'h04);
            wr(8'h04, 32'h0);
            cyc(3);
            chk("group auto clear", 0, o_group_req);
        end
        pl(6'h02);
        cyc(3);
        chk("end group", 1, o_group_req);
        chk("end prio", 4, o_prio_src);
        wr(8'h0C, 32'h0);
        cyc(3);
        chk("group gated", 0, o_group_req);
        // bit period rows: 8 or 16 base ticks, internal or timer base
        for (int i = 0; i < 3; i++) begin
            tmr_on <= (i == 2);
            wr(8'h00, {22'h0, cc[i]});
            cyc(40);
            for (n = 0; n < 40 && o_bit_tick !== 1'b1; n++) cyc(1);
            for (n = 1; n < 40; n++) begin
                cyc(1);
                if (o_bit_tick === 1'b1) break;
            end
            chk("bit period", pp[i], n);
        end
        print_verdict();
    end
endmodule
